// ===== osc_pkg.sv
`default_nettype none
package osc_pkg;

  // ---------------------------------------------------------------------------
  // register map (byte addresses on apb)
  // ---------------------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_TUNE    = 12'h004;
  localparam logic [11:0] ADDR_TUNE2   = 12'h008;
  localparam logic [11:0] ADDR_KEY     = 12'h00c;

  // ---------------------------------------------------------------------------
  // control field positions
  // ---------------------------------------------------------------------------
  localparam int POS_CUR     = 12;
  localparam int POS_REQ     = 8;
  localparam int POS_LOCK    = 7;
  localparam int POS_PLL     = 5;
  localparam int POS_DITHER  = 4;
  localparam int POS_FAIL    = 3;
  localparam int POS_SEQEN   = 2;
  localparam int POS_SWITCH  = 0;

  // ---------------------------------------------------------------------------
  // source group codes and unlock keys
  // ---------------------------------------------------------------------------
  localparam logic [2:0] GRP_FRC      = 3'h0;
  localparam logic [2:0] GRP_FRC_PLL  = 3'h1;
  localparam logic [2:0] GRP_PRI      = 3'h2;
  localparam logic [2:0] GRP_PRI_PLL  = 3'h3;
  localparam logic [7:0] KEY_LO_1     = 8'h46;
  localparam logic [7:0] KEY_LO_2     = 8'h57;
  localparam logic [7:0] KEY_HI_1     = 8'h78;
  localparam logic [7:0] KEY_HI_2     = 8'h9a;
  localparam logic [3:0] TUNE_RESET   = 4'h0;

  typedef enum logic [1:0] {
    OSC_KEY_IDLE = 2'b00,
    OSC_KEY_ONE  = 2'b01,
    OSC_KEY_OPEN = 2'b10
  } osc_key_t;

  typedef enum logic [1:0] {
    OSC_SW_IDLE = 2'b00,
    OSC_SW_WAIT = 2'b01
  } osc_sw_t;

  typedef struct packed {
    logic [2:0]  current_source_group;
    logic [2:0]  requested_source_group;
    logic        config_lock;
    logic        pll_locked;
    logic        dither_enable;
    logic        clock_fail_flag;
    logic        tune_sequencer_enable;
    logic        switch_request;
    logic [15:0] tune;
    logic [15:0] tune2;
    osc_key_t    key_lo;
    osc_key_t    key_hi;
    osc_sw_t     sw;
    logic [3:0]  trim;
    logic        start_switch;
    logic [31:0] prdata;
    logic        init_done;
  } osc_state_t;

endpackage : osc_pkg
`default_nettype wire

// ===== osc_switch_tune.sv
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none
// Notes on behaviour
// R1 - current group reads 000 frc, 001 frc+pll, 010 primary, 011 primary+pll
// R2 - current group is frc in reset, loaded from initial group at first clock, then from requested group on switch done
// R3 - monitor failure forces current group to frc
// R4 - writable 3-bit requested group names the next switch target
// R5 - lock set with configuration bit 1 high rejects clock and pll changes
// R6 - lock bit ignores writes of zero, clears only at reset
// R7 - pll locked bit clears on reset, switch start, lock loss; sets on lock
// R8 - pll locked bit reads zero when current group has no pll
// R9 - dither enable bit turns pseudo-random dithering on or off
// R10 - fail flag set by monitor, cleared by reset, switch start, or software
// R11 - sequencer off uses base tune only; on selects by 3-bit pwm index
// R12 - index 001..011 selects sequence tune 1..3
// R13 - index 100..111 selects sequence tune 4..7 from second tuning register
// R14 - switch request cleared on reset, switch done, redundant switch, failover
// R15 - base tune is signed: 0000 centre, 0111 maximum, 1000 minimum
// R16 - initial group comes from nonvolatile bits; software may then change it
// R17 - unimplemented control bits 15, 11, 6 and 1 read zero
// R18 - software unlocks a byte with two key writes before one byte write
// R19 - config 1x no switching or monitor; 01 switching only; 00 both
// R20 - sequencer on with index 000 uses the base tune
// R21 - group updates only after new source runs; same-group request completes at once
module osc_switch_tune
  import osc_pkg::*;
(
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic             pready_out,
  output logic [31:0]      prdata_out,
  output logic             pslverr_out,
  input  wire logic [2:0]  initial_group_in,
  input  wire logic [1:0]  switch_monitor_config_in,
  input  wire logic        pll_lock_in,
  input  wire logic        source_ready_in,
  input  wire logic        failsafe_monitor_fail_in,
  input  wire logic [2:0]  pwm_index_in,
  output logic [2:0]       select_group_out,
  output logic             switch_start_out,
  output logic             dither_enable_out,
  output logic             monitor_enable_out,
  output logic [3:0]       frc_trim_out
);

  osc_state_t q;
  osc_state_t next_q;

  logic [2:0] pll_s;
  logic [2:0] rdy_s;
  logic [2:0] fail_s;
  logic [5:0] idx_s0;
  logic [5:0] idx_s1;
  logic       idx_ok;

  // ---------------------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      pll_s  <= 3'h0;
      rdy_s  <= 3'h0;
      fail_s <= 3'h0;
      idx_s0 <= 6'h00;
      idx_s1 <= 6'h00;
    end else begin
      pll_s  <= {pll_s[1:0], pll_lock_in};
      rdy_s  <= {rdy_s[1:0], source_ready_in};
      fail_s <= {fail_s[1:0], failsafe_monitor_fail_in};
      idx_s0 <= {idx_s0[2:0], pwm_index_in};
      // upper half: accepted index; lower half: last synchronised sample
      idx_s1 <= {idx_ok ? idx_s0[5:3] : idx_s1[5:3], idx_s0[5:3]};
    end
  end

  logic       pll_sync;
  logic       rdy_sync;
  logic       fail_rise;
  logic [2:0] pwm_idx;
  assign pll_sync  = pll_s[1];
  assign rdy_sync  = rdy_s[1];
  assign fail_rise = fail_s[1] & ~fail_s[2];
  // the index is a word from another domain: its bits may land in different
  // cycles, so it is accepted only once two synchronised samples agree
  assign idx_ok    = (idx_s0[5:3] == idx_s1[2:0]);
  assign pwm_idx   = idx_s1[5:3];

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  logic       wr_acc;
  logic       rd_acc;
  logic       mapped;
  logic       cfg_locked;
  logic       switching_ok;
  logic       monitor_ok;
  logic       pll_group;
  logic [31:0] ctrl_rd;

  assign wr_acc = psel_in & penable_in & pwrite_in;
  assign rd_acc = psel_in & penable_in & ~pwrite_in;
  assign mapped = (paddr_in == ADDR_CONTROL) | (paddr_in == ADDR_TUNE) |
                  (paddr_in == ADDR_TUNE2) | (paddr_in == ADDR_KEY);

  assign switching_ok = ~switch_monitor_config_in[1];                      // R19
  assign monitor_ok   = (switch_monitor_config_in == 2'h0);                // R19
  assign cfg_locked   = q.config_lock & switch_monitor_config_in[1];       // R5
  assign pll_group    = (q.current_source_group == GRP_FRC_PLL) |
                        (q.current_source_group == GRP_PRI_PLL);

  always_comb begin
    ctrl_rd = 32'h0;                                                       // R17
    ctrl_rd[POS_CUR +: 3] = q.current_source_group;                        // R1
    ctrl_rd[POS_REQ +: 3] = q.requested_source_group;
    ctrl_rd[POS_LOCK]     = q.config_lock;
    ctrl_rd[POS_PLL]      = q.pll_locked & pll_group;                      // R8
    ctrl_rd[POS_DITHER]   = q.dither_enable;
    ctrl_rd[POS_FAIL]     = q.clock_fail_flag;
    ctrl_rd[POS_SEQEN]    = q.tune_sequencer_enable;
    ctrl_rd[POS_SWITCH]   = q.switch_request;
  end

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  logic lo_ok;
  logic hi_ok;
  logic key_wr;
  logic ctl_wr;

  always_comb begin
    next_q = q;
    next_q.start_switch = 1'b0;
    key_wr = wr_acc & (paddr_in == ADDR_KEY);
    ctl_wr = wr_acc & (paddr_in == ADDR_CONTROL);
    lo_ok  = (q.key_lo == OSC_KEY_OPEN);
    hi_ok  = (q.key_hi == OSC_KEY_OPEN);

    // ---------------------------------------------------------------------------
    // initial group taken at first clock after reset
    // ---------------------------------------------------------------------------
    if (!q.init_done) begin
      next_q.init_done              = 1'b1;
      next_q.current_source_group   = initial_group_in;                    // R16
      next_q.requested_source_group = initial_group_in;                    // R16
    end

    // ---------------------------------------------------------------------------
    // unlock windows: a key pair opens one following write
    // ---------------------------------------------------------------------------
    if (wr_acc) begin
      unique case (q.key_lo)                                               // R18
        OSC_KEY_IDLE: next_q.key_lo = (key_wr && pwdata_in[7:0] == KEY_LO_1) ?
                                      OSC_KEY_ONE : OSC_KEY_IDLE;
        OSC_KEY_ONE:  next_q.key_lo = (key_wr && pwdata_in[7:0] == KEY_LO_2) ?
                                      OSC_KEY_OPEN : OSC_KEY_IDLE;
        OSC_KEY_OPEN: next_q.key_lo = OSC_KEY_IDLE;
        default:      next_q.key_lo = OSC_KEY_IDLE;
      endcase
      unique case (q.key_hi)                                               // R18
        OSC_KEY_IDLE: next_q.key_hi = (key_wr && pwdata_in[15:8] == KEY_HI_1) ?
                                      OSC_KEY_ONE : OSC_KEY_IDLE;
        OSC_KEY_ONE:  next_q.key_hi = (key_wr && pwdata_in[15:8] == KEY_HI_2) ?
                                      OSC_KEY_OPEN : OSC_KEY_IDLE;
        OSC_KEY_OPEN: next_q.key_hi = OSC_KEY_IDLE;
        default:      next_q.key_hi = OSC_KEY_IDLE;
      endcase
    end

    // ---------------------------------------------------------------------------
    // control register writes
    // ---------------------------------------------------------------------------
    if (ctl_wr && pstrb_in[1] && hi_ok && !cfg_locked) begin               // R5
      next_q.requested_source_group = pwdata_in[POS_REQ +: 3];             // R4
    end
    if (ctl_wr && pstrb_in[0] && lo_ok) begin
      if (pwdata_in[POS_LOCK]) begin
        next_q.config_lock = 1'b1;                                         // R6
      end
      next_q.dither_enable         = pwdata_in[POS_DITHER];                // R9
      next_q.tune_sequencer_enable = pwdata_in[POS_SEQEN];
      if (!pwdata_in[POS_FAIL]) begin
        next_q.clock_fail_flag = 1'b0;                                     // R10
      end
      if (pwdata_in[POS_SWITCH] && switching_ok && !cfg_locked) begin      // R5
        next_q.switch_request = 1'b1;                                      // R14
      end
    end

    // ---------------------------------------------------------------------------
    // tuning register writes
    // ---------------------------------------------------------------------------
    if (wr_acc && paddr_in == ADDR_TUNE && !cfg_locked) begin              // R5
      if (pstrb_in[0]) next_q.tune[7:0]  = pwdata_in[7:0];
      if (pstrb_in[1]) next_q.tune[15:8] = pwdata_in[15:8];
    end
    if (wr_acc && paddr_in == ADDR_TUNE2 && !cfg_locked) begin             // R5
      if (pstrb_in[0]) next_q.tune2[7:0]  = pwdata_in[7:0];
      if (pstrb_in[1]) next_q.tune2[15:8] = pwdata_in[15:8];
    end

    // ---------------------------------------------------------------------------
    // switch sequencer
    // ---------------------------------------------------------------------------
    unique case (q.sw)
      OSC_SW_IDLE: begin
        if (q.switch_request) begin
          if (q.requested_source_group == q.current_source_group) begin
            next_q.switch_request = 1'b0;                                  // R21
          end else begin
            next_q.sw              = OSC_SW_WAIT;
            next_q.start_switch    = 1'b1;
            next_q.pll_locked      = 1'b0;                                 // R7
            next_q.clock_fail_flag = 1'b0;                                 // R10
          end
        end
      end
      OSC_SW_WAIT: begin
        if (rdy_sync && !q.start_switch) begin
          next_q.current_source_group = q.requested_source_group;          // R2
          next_q.switch_request       = 1'b0;                              // R14
          next_q.sw                   = OSC_SW_IDLE;                       // R21
        end
      end
      default: next_q.sw = OSC_SW_IDLE;
    endcase

    // ---------------------------------------------------------------------------
    // pll lock tracking outside a switch start
    // ---------------------------------------------------------------------------
    if (!next_q.start_switch) begin
      if (!pll_sync) next_q.pll_locked = 1'b0;                             // R7
      else if (q.sw == OSC_SW_IDLE) next_q.pll_locked = 1'b1;              // R7
    end

    // ---------------------------------------------------------------------------
    // monitor failover has the last word
    // ---------------------------------------------------------------------------
    if (fail_rise && monitor_ok) begin
      next_q.clock_fail_flag      = 1'b1;                                  // R10
      next_q.current_source_group = GRP_FRC;                               // R3
      next_q.switch_request       = 1'b0;                                  // R14
      next_q.sw                   = OSC_SW_IDLE;
      // a start in the same cycle would steer away from fast rc again
      next_q.start_switch         = 1'b0;
    end

    // ---------------------------------------------------------------------------
    // tune selection
    // ---------------------------------------------------------------------------
    if (!q.tune_sequencer_enable || pwm_idx == 3'h0) begin
      next_q.trim = q.tune[3:0];                                           // R11 R20 R15
    end else if (!pwm_idx[2]) begin
      next_q.trim = q.tune[pwm_idx * 4 +: 4];                              // R12
    end else begin
      next_q.trim = q.tune2[pwm_idx[1:0] * 4 +: 4];                        // R13
    end

    // ---------------------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------------------
    next_q.prdata = 32'h0;
    if (psel_in && !penable_in && !pwrite_in) begin
      unique case (paddr_in)
        ADDR_CONTROL: next_q.prdata = ctrl_rd;
        ADDR_TUNE:    next_q.prdata = {16'h0, q.tune};
        ADDR_TUNE2:   next_q.prdata = {16'h0, q.tune2};
        default:      next_q.prdata = 32'h0;
      endcase
    end
    if (rd_acc) begin
      next_q.prdata = q.prdata;
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      q                      <= '0;
      q.current_source_group <= GRP_FRC;                                   // R2
      q.tune                 <= {4{TUNE_RESET}};
      q.tune2                <= {4{TUNE_RESET}};
      q.key_lo               <= OSC_KEY_IDLE;
      q.key_hi               <= OSC_KEY_IDLE;
      q.sw                   <= OSC_SW_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign pready_out         = 1'b1;
  assign pslverr_out        = psel_in & penable_in & ~mapped;
  assign prdata_out         = q.prdata;
  assign select_group_out   = q.current_source_group;
  assign switch_start_out   = q.start_switch;
  assign dither_enable_out  = q.dither_enable;                             // R9
  assign monitor_enable_out = monitor_ok;
  assign frc_trim_out       = q.trim;

endmodule : osc_switch_tune
`default_nettype wire

// ===== osc_switch_tune_asserts.sv
`default_nettype none
module osc_switch_tune_asserts
  import osc_pkg::*;
(
  input wire logic       clock_in,
  input wire logic       rst_in,
  input wire logic       psel_in,
  input wire logic       penable_in,
  input wire logic       pwrite_in,
  input wire logic [1:0] switch_monitor_config_in,
  input wire logic       failsafe_monitor_fail_in,
  input wire logic [2:0] pwm_index_in,
  input wire logic [2:0] select_group_out,
  input wire logic       switch_start_out,
  input wire logic       dither_enable_out,
  input wire logic       monitor_enable_out,
  input wire logic [3:0] frc_trim_out,
  input wire logic       pslverr_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  reset_group_a: assert property (
    $fell(rst_in) |-> select_group_out == GRP_FRC && !switch_start_out)
    else $error("group not fast rc after reset");
  failover_frc_a: assert property (
    $rose(failsafe_monitor_fail_in) && switch_monitor_config_in == 2'h0
      |-> ##[1:5] select_group_out == GRP_FRC)
    else $error("failover did not select fast rc");
  monitor_cfg_a: assert property (
    monitor_enable_out == (switch_monitor_config_in == 2'h0))
    else $error("monitor enable does not follow config");
  no_switch_a: assert property (
    switch_monitor_config_in[1] |-> !switch_start_out)
    else $error("switch started while switching disabled");
  start_pulse_a: assert property (
    switch_start_out |=> !switch_start_out)
    else $error("switch start longer than one cycle");
  group_wait_a: assert property (
    switch_start_out |=> $stable(select_group_out))
    else $error("group changed before new source ran");
  dither_hold_a: assert property (
    !(psel_in && penable_in && pwrite_in) |=> $stable(dither_enable_out))
    else $error("dither changed without a write");
  trim_hold_a: assert property (
    (!(psel_in && pwrite_in) && $stable(pwm_index_in)) [*5] |=> $stable(frc_trim_out))
    else $error("trim changed with steady inputs");
  switch_c: cover property (switch_start_out);
  fail_c: cover property ($rose(failsafe_monitor_fail_in));
  slverr_c: cover property (pslverr_out);
endmodule : osc_switch_tune_asserts
bind osc_switch_tune osc_switch_tune_asserts osc_switch_tune_asserts_i (
  .clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .switch_monitor_config_in,
  .failsafe_monitor_fail_in, .pwm_index_in, .select_group_out, .switch_start_out,
  .dither_enable_out, .monitor_enable_out, .frc_trim_out, .pslverr_out);
`default_nettype wire

// ===== osc_switch_tune_tb.sv
`default_nettype none
module osc_switch_tune_tb
  import osc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock_in = 1'h0, rst_in = 1'h1, psel_in = 1'h0, penable_in = 1'h0;
  logic        pwrite_in = 1'h0, pll_lock_in = 1'h1, source_ready_in = 1'h0, slv;
  logic        failsafe_monitor_fail_in = 1'h0, pready_out, pslverr_out;
  logic        switch_start_out, dither_enable_out, monitor_enable_out;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [3:0]  pstrb_in = 4'h0, frc_trim_out;
  logic [2:0]  initial_group_in = GRP_PRI_PLL, pwm_index_in = 3'h0, select_group_out;
  logic [1:0]  switch_monitor_config_in = 2'h1;
  int          err_count = 0, checked = 0, starts = 0;
  always #25 clock_in = ~clock_in;
  always @(negedge clock_in) if (switch_start_out === 1'h1) starts++;
  osc_switch_tune osc_switch_tune_i (.clock_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .pstrb_in, .pready_out, .prdata_out, .pslverr_out,
    .initial_group_in, .switch_monitor_config_in, .pll_lock_in, .source_ready_in,
    .failsafe_monitor_fail_in, .pwm_index_in, .select_group_out, .switch_start_out,
    .dither_enable_out, .monitor_enable_out, .frc_trim_out);
  // ---------------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------------
  task automatic stop_test();
    if (err_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clock_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    pstrb_in <= s;
    @(posedge clock_in);
    penable_in <= 1'h1;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    if (pready_out !== 1'h1) begin
      err_count++;
      stop_test();
    end
    rd = prdata_out;
    slv = pslverr_out;
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask : apb
  // both key pairs open both bytes for the next write only
  task automatic wctl(input logic [31:0] d, input logic [3:0] s);
    apb(1'h1, ADDR_KEY, 32'h7846, 4'h3);
    apb(1'h1, ADDR_KEY, 32'h9a57, 4'h3);
    apb(1'h1, ADDR_CONTROL, d, s);
  endtask : wctl
  task automatic sweep(input logic seq);
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_in);
      pwm_index_in <= i[2:0];
      repeat (7) @(negedge clock_in);
      check("trim", frc_trim_out, (seq && i != 0) ? i : 32'h8);
    end
  endtask : sweep
  task automatic wait_grp(input logic [2:0] g);
    for (int n = 0; n < 40 && select_group_out !== g; n++) @(negedge clock_in);
    check("group", select_group_out, g);
  endtask : wait_grp
  // ---------------------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'h0;
    repeat (2) @(posedge clock_in);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("ctl_reset", rd, 32'h3320);
    check("monitor_off", monitor_enable_out, 32'h0);
    apb(1'h1, ADDR_TUNE, 32'h3218, 4'hf);
    apb(1'h1, ADDR_TUNE2, 32'h7654, 4'hf);
    apb(1'h0, ADDR_TUNE, 32'h0, 4'h0);
    check("tune", rd, 32'h3218);
    sweep(1'h0);
    wctl(32'h14, 4'h1);
    sweep(1'h1);
    apb(1'h1, ADDR_CONTROL, 32'h0, 4'h1);
    @(negedge clock_in);
    check("dither", dither_enable_out, 32'h1);
    wctl(32'h0115, 4'h3);
    repeat (3) @(negedge clock_in);
    check("starts", starts, 32'h1);
    check("group_hold", select_group_out, GRP_PRI_PLL);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("ctl_pending", rd, 32'h3115);
    source_ready_in <= 1'h1;
    pll_lock_in <= 1'h1;
    wait_grp(GRP_FRC_PLL);
    repeat (4) @(negedge clock_in);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("ctl_done", rd, 32'h1134);
    pll_lock_in <= 1'h0;
    source_ready_in <= 1'h0;
    repeat (4) @(negedge clock_in);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("pll_loss", rd, 32'h1114);
    wctl(32'h0115, 4'h3);
    repeat (4) @(negedge clock_in);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("redundant", {rd[0], starts[30:0]}, 32'h1);
    switch_monitor_config_in <= 2'h2;
    wctl(32'h94, 4'h1);
    wctl(32'h14, 4'h1);
    apb(1'h1, ADDR_TUNE, 32'h0, 4'hf);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("lock", rd & 32'h80, 32'h80);
    apb(1'h0, ADDR_TUNE, 32'h0, 4'h0);
    check("tune_locked", rd, 32'h3218);
    switch_monitor_config_in <= 2'h0;
    apb(1'h1, ADDR_TUNE, 32'h3217, 4'hf);
    apb(1'h0, ADDR_TUNE, 32'h0, 4'h0);
    check("tune_open", rd, 32'h3217);
    check("monitor_on", monitor_enable_out, 32'h1);
    failsafe_monitor_fail_in <= 1'h1;
    pll_lock_in <= 1'h1;
    wait_grp(GRP_FRC);
    repeat (4) @(negedge clock_in);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("failover", rd & 32'hfffff8ff, 32'h9c);
    wctl(32'h94, 4'h1);
    apb(1'h0, ADDR_CONTROL, 32'h0, 4'h0);
    check("fail_clear", rd & 32'h8, 32'h0);
    apb(1'h0, 12'h010, 32'h0, 4'h0);
    check("unmapped", slv, 32'h1);
    stop_test();
  end
endmodule : osc_switch_tune_tb
`default_nettype wire
